// >>> bench/prog_link_model.sv
// Behavioural programmer on the far side of the serial programming link.
`timescale 1ns/1ns
`default_nettype none
module prog_link_model (
   input wire logic mclk,
   input wire logic link_idle,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic bit_tick
);
   int tick_count;

   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      bit_tick = 1'b0;
      tick_count = 0;
   end

   // Bit periods run only while the device holds a turnaround, so idle bits can be counted.
   always @(posedge mclk) begin
      if (link_idle && bit_tick) begin
         tick_count = tick_count + 1;
      end
      #1;
      bit_tick = link_idle && !bit_tick;
   end

   ////////////////////////////////////////////////////////////
   // A frame goes out as whole bytes on consecutive cycles, first byte in the low bits.
   // A gap cycle follows so that the next frame never re-raises valid in the same step.
   task automatic send(input logic [71:0] v, input int n);
      for (int i = 0; i < n; i++) begin
         rx_valid = 1'b1;
         rx_data = v[8*i +: 8];
         @(posedge mclk);
         #1;
      end
      rx_valid = 1'b0;
      rx_data = ~rx_data; // A released line shows no stale byte.
      @(posedge mclk);
      #1;
   endtask

   // Loads one control register and waits a bounded time for the reply.
   task automatic load(input logic [3:0] a, output logic [7:0] d, output int ticks,
                       output logic idle_at_tx);
      int n;
      tick_count = 0;
      send({64'h0, 4'h8, a}, 1);
      n = 0;
      while (tx_valid !== 1'b1 && n < 1000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      d = (n < 1000) ? tx_data : 8'hXX;
      ticks = tick_count;
      idle_at_tx = link_idle;
      @(posedge mclk);
      #1;
   endtask

   // Polls the enable flag until it reads one; gives up after a few tries.
   task automatic poll_enabled(output logic ok);
      logic [7:0] d;
      int t;
      logic li;
      ok = 1'b0;
      for (int i = 0; i < 4 && !ok; i++) begin
         load(4'h0, d, t, li);
         ok = (d === 8'h02);
      end
   endtask
endmodule
`default_nettype wire

// >>> bench/programming_link_nvm_access_tb.sv
// Self-checking testbench of the programming-link gate against a programmer model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin \
   checks_done++; \
   if ((got) !== (exp)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got); \
   end \
end
module programming_link_nvm_access_tb;
   logic mclk;
   logic rst;
   logic rx_valid;
   logic [7:0] rx_data;
   logic bit_tick;
   logic link_idle;
   logic tx_valid;
   logic [7:0] tx_data;
   logic programming_enabled_flag;
   logic cpu_data_rd;
   logic cpu_nvm_wr;
   logic [7:0] nvm_rd_data;
   logic cpu_stall;
   logic [7:0] cpu_rd_data;
   logic ext_nvm_wr;
   logic ext_nvm_rd;
   logic [2:0] ext_section;
   logic nvm_wr_en;
   logic nvm_rd_en;
   logic sleep_req;
   logic nvm_op_busy;
   logic flash_enable;
   int miscompares = 0;
   int checks_done = 0;

   prog_link_gate u_prog_link_gate (.mclk(mclk), .rst(rst), .rx_valid(rx_valid),
      .rx_data(rx_data), .bit_tick(bit_tick), .link_idle(link_idle), .tx_valid(tx_valid),
      .tx_data(tx_data), .programming_enabled_flag(programming_enabled_flag),
      .cpu_data_rd(cpu_data_rd), .cpu_nvm_wr(cpu_nvm_wr), .nvm_rd_data(nvm_rd_data),
      .cpu_stall(cpu_stall), .cpu_rd_data(cpu_rd_data), .ext_nvm_wr(ext_nvm_wr),
      .ext_nvm_rd(ext_nvm_rd), .ext_section(ext_section), .nvm_wr_en(nvm_wr_en),
      .nvm_rd_en(nvm_rd_en), .sleep_req(sleep_req), .nvm_op_busy(nvm_op_busy),
      .flash_enable(flash_enable));

   prog_link_model u_prog_link_model (.mclk(mclk), .link_idle(link_idle),
      .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid), .rx_data(rx_data),
      .bit_tick(bit_tick));

   // The clock toggles every half period of 25 ns.
   always #25 mclk = ~mclk;

   ////////////////////////////////////////////////////////////
   // Reset values seen through the link, including an unmapped control address.
   task automatic t_reset();
      logic [7:0] d;
      int t;
      logic li;
      `CHK("flag", 1'b0, programming_enabled_flag)
      u_prog_link_model.load(4'h0, d, t, li);
      `CHK("status", 8'h00, d)
      u_prog_link_model.load(4'h2, d, t, li);
      `CHK("guard_reset", 8'h00, d)
      `CHK("idle_reset", 130, t)
      u_prog_link_model.load(4'hF, d, t, li);
      `CHK("ident", prog_link_pkg::IDENT_CODE, d)
      u_prog_link_model.load(4'h1, d, t, li);
      `CHK("reserved", 8'h00, d)
   endtask

   // Every guard code, with reserved bits written high; ends on the shortest guard.
   task automatic t_guard();
      logic [7:0] d;
      int t;
      logic li;
      int extra;
      for (int g = 0; g < 8; g++) begin
         extra = (g == 7) ? 0 : (128 >> g);
         u_prog_link_model.send({56'h0, 5'h1F, g[2:0], 8'hC2}, 2);
         u_prog_link_model.load(4'h2, d, t, li);
         `CHK("guard_field", {5'h00, g[2:0]}, d)
         `CHK("idle_bits", extra + 2, t)
         `CHK("idle_at_reply", 1'b0, li)
      end
   endtask

   // A key wrong only in its last byte, a store of one, then the true key.
   task automatic t_key();
      logic ok;
      u_prog_link_model.send({64'hED89AB45CDD888FF, 8'hE0}, 9);
      `CHK("flag_bad_key", 1'b0, programming_enabled_flag)
      u_prog_link_model.send({56'h0, 8'h02, 8'hC0}, 2);
      `CHK("flag_store_one", 1'b0, programming_enabled_flag)
      u_prog_link_model.send({64'h1289AB45CDD888FF, 8'hE0}, 9);
      u_prog_link_model.poll_enabled(ok);
      `CHK("poll", 1'b1, ok)
      `CHK("flag_good_key", 1'b1, programming_enabled_flag)
   endtask

   // External access per section, an application write, then disabling by a store of zero.
   task automatic t_nvm();
      for (int s = 0; s < 5; s++) begin
         @(posedge mclk);
         #1;
         ext_section = s[2:0];
         ext_nvm_wr = 1'b1;
         ext_nvm_rd = 1'b1;
         #1;
         `CHK("ext_wr", (s < 2 || s == 4), nvm_wr_en)
         `CHK("ext_rd", 1'b1, nvm_rd_en)
      end
      @(posedge mclk);
      #1;
      ext_nvm_wr = 1'b0;
      cpu_nvm_wr = 1'b1;
      #1;
      `CHK("cpu_wr", 1'b0, nvm_wr_en)
      @(posedge mclk);
      #1;
      cpu_nvm_wr = 1'b0;
      ext_nvm_wr = 1'b1;
      ext_section = 3'h0;
      u_prog_link_model.send({56'h0, 8'h00, 8'hC0}, 2);
      `CHK("flag_cleared", 1'b0, programming_enabled_flag)
      `CHK("wr_locked", 1'b0, nvm_wr_en)
      `CHK("rd_locked", 1'b0, nvm_rd_en)
      ext_nvm_wr = 1'b0;
      ext_nvm_rd = 1'b0;
   endtask

   // An application read stalls one cycle and returns the array byte.
   task automatic t_cpu();
      @(posedge mclk);
      #1;
      cpu_data_rd = 1'b1;
      nvm_rd_data = 8'hA5;
      #1;
      `CHK("stall", 1'b1, cpu_stall)
      `CHK("cpu_rd_en", 1'b1, nvm_rd_en)
      @(posedge mclk);
      #1;
      cpu_data_rd = 1'b0;
      nvm_rd_data = 8'h3C;
      #1;
      `CHK("cpu_data", 8'hA5, cpu_rd_data)
      `CHK("stall_end", 1'b0, cpu_stall)
   endtask

   // Flash is off only when sleeping with no operation in flight.
   task automatic t_sleep();
      for (int k = 0; k < 4; k++) begin
         @(posedge mclk);
         #1;
         sleep_req = k[0];
         nvm_op_busy = k[1];
         #1;
         `CHK("flash_en", !(k[0] && !k[1]), flash_enable)
      end
   endtask

   ////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (miscompares == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Main sequence; the link model drives its own outputs from time zero.
   initial begin
      mclk = 1'b0;
      rst = 1'b1;
      cpu_data_rd = 1'b0;
      cpu_nvm_wr = 1'b0;
      nvm_rd_data = 8'h00;
      ext_nvm_wr = 1'b0;
      ext_nvm_rd = 1'b0;
      ext_section = 3'h0;
      sleep_req = 1'b0;
      nvm_op_busy = 1'b0;
      repeat (3) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_reset();
      t_guard();
      t_key();
      t_nvm();
      t_cpu();
      t_sleep();
      stop_test();
   end

   // The whole run needs about 1700 cycles; the watchdog allows well over that.
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      stop_test();
   end
endmodule
`default_nettype wire

// >>> hw/prog_link_gate.sv
// Programming-link control space, unlock gate and memory access gate.
//
// Operation
// RQ1: Memory programming is off after reset until a correct key arrives.
// RQ2: The only accepted key is the 64-bit constant 0x1289AB45CDD888FF.
// RQ3: The programmer polls the enable flag until it reads one.
// RQ4: Storing zero to the enable flag turns programming off.
// RQ5: Link registers live in their own space, reached by load/store commands.
// RQ6: Address 0x0F returns a read-only 8-bit identification code.
// RQ7: Address 0x02 holds a 3-bit guard field; bits 7:3 read zero.
// RQ8: Extra idle bits only on receive-to-transmit turnaround, none the other way.
// RQ9: Turnaround idle equals the guard time plus two idle bits.
// RQ10: Guard codes 0..7 give 128,64,32,16,8,4,2,0 extra bits.
// RQ11: Guard resets to 128 bits; programmer should shorten it.
// RQ12: Address 0x00 is status; bit 1 is the enable flag, rest zero.
// RQ13: Application reads all memory through mapped data locations.
// RQ14: An application data read stalls the processor one clock.
// RQ15: Application write or erase attempts have no effect.
// RQ16: Externally, signature and calibration sections stay read-only.
// RQ17: External writes only to lock bits, code and configuration.
// RQ18: Sleep with no programming active disables the flash.
// RQ19: Key command is opcode 0xE0 followed by eight key bytes.
// RQ20: Load command 1000 aaaa reads control register aaaa out.
// RQ21: Store command 1100 aaaa writes the next byte to register aaaa.
// RQ22: All eight key bytes are compared; any mismatch leaves programming off.
`timescale 1ns/1ns
`default_nettype none
module prog_link_gate (
   input wire logic mclk,
   input wire logic rst,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic bit_tick,
   output logic link_idle,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic programming_enabled_flag,
   input wire logic cpu_data_rd,
   input wire logic cpu_nvm_wr,
   input wire logic [7:0] nvm_rd_data,
   output logic cpu_stall,
   output logic [7:0] cpu_rd_data,
   input wire logic ext_nvm_wr,
   input wire logic ext_nvm_rd,
   input wire logic [2:0] ext_section,
   output logic nvm_wr_en,
   output logic nvm_rd_en,
   input wire logic sleep_req,
   input wire logic nvm_op_busy,
   output logic flash_enable
);
   ////////////////////////////////////////////////////////////////////////////////
   // Command decoder and control space.

   prog_link_pkg::link_state_t state;
   prog_link_pkg::link_state_t next_state;
   logic [2:0] key_idx;
   logic [2:0] next_key_idx;
   logic [3:0] store_addr;
   logic [3:0] next_store_addr;
   logic prog_en;
   logic next_prog_en;
   logic [2:0] guard_field;
   logic [2:0] next_guard_field;
   logic [7:0] load_data;
   logic [7:0] next_load_data;
   logic load_pending;
   logic next_load_pending;
   logic [7:0] ctrl_rd_byte;
   logic key_start;
   logic key_valid;
   logic key_ok;
   logic key_last_ok;
   logic guard_start;
   logic guard_busy;
   logic guard_done;
   logic rx_take;

   // Bytes arriving during a turnaround belong to nobody, since the link is half duplex.
   assign rx_take = rx_valid && !guard_busy;

   // The control space answers only through the load command, never through any I/O map.
   always_comb begin
      case (rx_data[3:0]) // RQ5
         prog_link_pkg::ADDR_LINK_STATUS:
            ctrl_rd_byte = 8'(prog_en) << prog_link_pkg::PROG_EN_BIT; // RQ12
         prog_link_pkg::ADDR_PHY_CONTROL:
            ctrl_rd_byte = {5'h00, guard_field}; // RQ7
         prog_link_pkg::ADDR_IDENT:
            ctrl_rd_byte = prog_link_pkg::IDENT_CODE; // RQ6
         default:
            ctrl_rd_byte = 8'h00; // RQ5
      endcase
   end

   assign key_start = (state == prog_link_pkg::ST_CMD) && rx_take &&
                      (rx_data == prog_link_pkg::KEY_SIGNAL_OP); // RQ19
   assign key_valid = (state == prog_link_pkg::ST_KEY) && rx_take;
   assign key_last_ok = key_valid && (key_idx == prog_link_pkg::KEY_LAST) && key_ok;
   assign guard_start = (state == prog_link_pkg::ST_CMD) && rx_take &&
                        (rx_data[7:4] == prog_link_pkg::CS_LOAD_HI); // RQ8

   // Next state of the decoder, the enable flag and the guard field.
   always_comb begin
      next_state = state;
      next_key_idx = key_idx;
      next_store_addr = store_addr;
      next_prog_en = prog_en;
      next_guard_field = guard_field;
      next_load_data = load_data;
      next_load_pending = load_pending && !guard_done;
      case (state)
         prog_link_pkg::ST_CMD: begin
            if (key_start) begin
               next_state = prog_link_pkg::ST_KEY; // RQ19
               next_key_idx = 3'h0;
            end else if (guard_start) begin
               next_load_data = ctrl_rd_byte; // RQ20
               next_load_pending = 1'b1;
            end else if (rx_take && rx_data[7:4] == prog_link_pkg::CS_STORE_HI) begin
               next_state = prog_link_pkg::ST_STORE; // RQ21
               next_store_addr = rx_data[3:0];
            end
         end
         prog_link_pkg::ST_STORE: begin
            if (rx_take) begin
               next_state = prog_link_pkg::ST_CMD;
               if (store_addr == prog_link_pkg::ADDR_LINK_STATUS &&
                   !rx_data[prog_link_pkg::PROG_EN_BIT]) begin
                  next_prog_en = 1'b0; // RQ4
               end
               if (store_addr == prog_link_pkg::ADDR_PHY_CONTROL) begin
                  next_guard_field = rx_data[2:0]; // RQ7 RQ21
               end
            end
         end
         prog_link_pkg::ST_KEY: begin
            if (key_valid) begin
               next_key_idx = 3'(key_idx + 3'h1);
               if (key_idx == prog_link_pkg::KEY_LAST) begin
                  next_state = prog_link_pkg::ST_CMD;
                  if (key_ok) begin
                     next_prog_en = 1'b1; // RQ1 RQ2 RQ22
                  end
               end
            end
         end
         default: begin
            next_state = prog_link_pkg::ST_CMD;
         end
      endcase
   end

   // Reset leaves programming off and the longest guard time in place.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= prog_link_pkg::ST_CMD;
         key_idx <= 3'h0;
         store_addr <= 4'h0;
         prog_en <= 1'b0; // RQ1
         guard_field <= prog_link_pkg::GUARD_RESET; // RQ11
         load_data <= 8'h00;
         load_pending <= 1'b0;
      end else begin
         state <= next_state;
         key_idx <= next_key_idx;
         store_addr <= next_store_addr;
         prog_en <= next_prog_en;
         guard_field <= next_guard_field;
         load_data <= next_load_data;
         load_pending <= next_load_pending;
      end
   end

   unlock_key_check u_key (
      .mclk(mclk),
      .rst(rst),
      .key_start(key_start),
      .key_valid(key_valid),
      .key_idx(key_idx),
      .key_byte(rx_data),
      .key_ok(key_ok)
   );

   // Turnaround is timed only for loads; transmit-to-receive needs no delay.
   turnaround_guard u_guard (
      .mclk(mclk),
      .rst(rst),
      .guard_start(guard_start),
      .guard_time(guard_field),
      .bit_tick(bit_tick),
      .guard_busy(guard_busy),
      .guard_done(guard_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit byte register.

   logic [7:0] next_tx_data;
   logic next_tx_valid;

   // The loaded byte leaves only once the whole idle period has been driven.
   always_comb begin
      next_tx_valid = load_pending && guard_done; // RQ8 RQ9
      next_tx_data = next_tx_valid ? load_data : tx_data;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_valid <= 1'b0;
         tx_data <= 8'h00;
      end else begin
         tx_valid <= next_tx_valid;
         tx_data <= next_tx_data;
      end
   end

   assign link_idle = guard_busy;
   assign programming_enabled_flag = prog_en;

   ////////////////////////////////////////////////////////////////////////////////
   // Memory access gate.

   logic sec_writable;
   logic [7:0] next_cpu_rd_data;

   // Signature and calibration are factory data, so no party may write them.
   assign sec_writable = (ext_section == prog_link_pkg::SEC_CODE) ||
                         (ext_section == prog_link_pkg::SEC_CONFIG) ||
                         (ext_section == prog_link_pkg::SEC_LOCK); // RQ16 RQ17
   // Application writes never reach the array; only the unlocked programmer does.
   assign nvm_wr_en = ext_nvm_wr && prog_en && sec_writable && !cpu_nvm_wr; // RQ15 RQ17
   assign nvm_rd_en = (ext_nvm_rd && prog_en) || cpu_data_rd; // RQ13 RQ16
   // Single read port: the data fetch takes the slot of the next instruction fetch.
   assign cpu_stall = cpu_data_rd; // RQ14
   // Flash powers down in sleep unless a programming operation still runs.
   assign flash_enable = !(sleep_req && !nvm_op_busy); // RQ18

   // Read data is captured the cycle the application read is issued.
   always_comb begin
      next_cpu_rd_data = cpu_data_rd ? nvm_rd_data : cpu_rd_data; // RQ13
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cpu_rd_data <= 8'h00;
      end else begin
         cpu_rd_data <= next_cpu_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_enable_cause: assert property (@(posedge mclk) disable iff (rst) // RQ1
      $rose(prog_en) |-> $past(key_last_ok))
      else $error("programming enabled without a full correct key");
   a_key_enables: assert property (@(posedge mclk) disable iff (rst) // RQ22
      key_last_ok |=> prog_en)
      else $error("correct key did not enable programming");
   a_store_zero_clears: assert property (@(posedge mclk) disable iff (rst) // RQ4
      (state == prog_link_pkg::ST_STORE && rx_take &&
       store_addr == prog_link_pkg::ADDR_LINK_STATUS &&
       !rx_data[prog_link_pkg::PROG_EN_BIT]) |=> !prog_en)
      else $error("store of zero did not clear the enable flag");
   a_status_read: assert property (@(posedge mclk) disable iff (rst) // RQ12
      (guard_start && rx_data[3:0] == prog_link_pkg::ADDR_LINK_STATUS)
         |=> load_data == {6'h00, prog_en, 1'b0})
      else $error("status read does not match the enable flag");
   a_control_read: assert property (@(posedge mclk) disable iff (rst) // RQ7
      (guard_start && rx_data[3:0] == prog_link_pkg::ADDR_PHY_CONTROL)
         |=> load_data[7:3] == 5'h00 && load_data[2:0] == guard_field)
      else $error("control read has reserved bits set or wrong guard field");
   a_ident_read: assert property (@(posedge mclk) disable iff (rst) // RQ6
      (guard_start && rx_data[3:0] == prog_link_pkg::ADDR_IDENT)
         |=> load_data == prog_link_pkg::IDENT_CODE)
      else $error("identification read returned a wrong code");
   a_tx_after_guard: assert property (@(posedge mclk) disable iff (rst) // RQ8
      tx_valid |-> $past(guard_done) && $past(load_pending))
      else $error("byte sent before the turnaround idle ended");
   a_stall_data_rd: assert property (@(posedge mclk) disable iff (rst) // RQ14
      cpu_data_rd |-> cpu_stall ##1 (cpu_rd_data == $past(nvm_rd_data)))
      else $error("data read did not stall or capture data");
   a_app_no_write: assert property (@(posedge mclk) disable iff (rst) // RQ15
      nvm_wr_en |-> prog_en && !cpu_nvm_wr)
      else $error("array written without the unlocked programmer");
   a_ro_sections: assert property (@(posedge mclk) disable iff (rst) // RQ16
      nvm_wr_en |-> ext_section != prog_link_pkg::SEC_SIGNATURE &&
                    ext_section != prog_link_pkg::SEC_CALIB)
      else $error("write reached a read-only section");
   a_sleep_flash_off: assert property (@(posedge mclk) disable iff (rst) // RQ18
      (sleep_req && !nvm_op_busy) |-> !flash_enable)
      else $error("flash left enabled in idle sleep");

   c_unlock: cover property (@(posedge mclk) disable iff (rst) $rose(prog_en));
   c_load_reply: cover property (@(posedge mclk) disable iff (rst) tx_valid);
   c_guard_write: cover property (@(posedge mclk) disable iff (rst)
      state == prog_link_pkg::ST_STORE && rx_take &&
      store_addr == prog_link_pkg::ADDR_PHY_CONTROL);
   c_relock: cover property (@(posedge mclk) disable iff (rst) $fell(prog_en));
endmodule
`default_nettype wire

// >>> hw/turnaround_guard.sv
// Counts link idle bits before the device turns the link from receive to transmit.
`timescale 1ns/1ns
`default_nettype none
module turnaround_guard (
   input wire logic mclk,
   input wire logic rst,
   input wire logic guard_start,
   input wire logic [2:0] guard_time,
   input wire logic bit_tick,
   output logic guard_busy,
   output logic guard_done
);
   logic [7:0] idle_left;
   logic [7:0] next_idle_left;

   // Total idle is the selected extra bits plus the two fixed ones.
   always_comb begin
      next_idle_left = idle_left;
      if (guard_start) begin
         next_idle_left = 8'(prog_link_pkg::guard_extra(guard_time) +
                          prog_link_pkg::BASE_IDLE_BITS); // RQ9 RQ10
      end else if (bit_tick && idle_left != 8'h00) begin
         next_idle_left = 8'(idle_left - 8'h01);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         idle_left <= 8'h00;
      end else begin
         idle_left <= next_idle_left;
      end
   end

   assign guard_busy = (idle_left != 8'h00); // RQ8
   assign guard_done = bit_tick && (idle_left == 8'h01);

   a_guard_load: assert property (@(posedge mclk) disable iff (rst) // RQ9
      guard_start |=> idle_left ==
         8'(prog_link_pkg::guard_extra($past(guard_time)) + prog_link_pkg::BASE_IDLE_BITS))
      else $error("guard count not loaded with extra plus two idle bits");
endmodule
`default_nettype wire

// >>> hw/unlock_key_check.sv
// Byte-wise comparison of the received unlock key against the fixed constant.
`timescale 1ns/1ns
`default_nettype none
module unlock_key_check (
   input wire logic mclk,
   input wire logic rst,
   input wire logic key_start,
   input wire logic key_valid,
   input wire logic [2:0] key_idx,
   input wire logic [7:0] key_byte,
   output logic key_ok
);
   logic match_so_far;
   logic next_match_so_far;
   logic [prog_link_pkg::KEY_BYTES-1:0] hit;

   // Each entry compares the incoming byte with its own slice of the key.
   genvar i;
   generate
      for (i = 0; i < prog_link_pkg::KEY_BYTES; i++) begin : g_byte
         assign hit[i] = (key_idx == 3'(i)) &&
                         (key_byte == prog_link_pkg::UNLOCK_KEY[i*8 +: 8]); // RQ2
      end
   endgenerate

   // Whole key is good only if this byte and every earlier one matched.
   assign key_ok = match_so_far && (|hit); // RQ22

   // A single mismatch spoils the rest of the sequence.
   always_comb begin
      next_match_so_far = match_so_far;
      if (key_start) begin
         next_match_so_far = 1'b1;
      end else if (key_valid) begin
         next_match_so_far = match_so_far && (|hit); // RQ22
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         match_so_far <= 1'b0;
      end else begin
         match_so_far <= next_match_so_far;
      end
   end
endmodule
`default_nettype wire

// >>> inc/prog_link_pkg.sv
// Constants shared by the programming-link control space and the memory access gate.
package prog_link_pkg;
   // Control-space addresses (4-bit direct address of the load and store commands).
   localparam logic [3:0] ADDR_LINK_STATUS = 4'h0;
   localparam logic [3:0] ADDR_PHY_CONTROL = 4'h2;
   localparam logic [3:0] ADDR_IDENT = 4'hF;
   // Field positions and masks.
   localparam int PROG_EN_BIT = 1;
   localparam logic [7:0] LINK_STATUS_MASK = 8'h02;
   localparam logic [7:0] PHY_CONTROL_MASK = 8'h07;
   localparam logic [7:0] LINK_STATUS_RESET = 8'h00;
   localparam logic [2:0] GUARD_RESET = 3'h0;
   // Identification code; the value is arbitrary.
   localparam logic [7:0] IDENT_CODE = 8'h5A;
   // Opcodes: key command is exact, load and store carry the address in the low nibble.
   localparam logic [7:0] KEY_SIGNAL_OP = 8'hE0;
   localparam logic [3:0] CS_LOAD_HI = 4'h8;
   localparam logic [3:0] CS_STORE_HI = 4'hC;
   // Unlock key, sent least significant byte first.
   localparam logic [63:0] UNLOCK_KEY = 64'h1289AB45CDD888FF;
   localparam int KEY_BYTES = 8;
   localparam logic [2:0] KEY_LAST = 3'h7;
   // Idle bits always present on a receive-to-transmit turnaround.
   localparam logic [7:0] BASE_IDLE_BITS = 8'h02;
   // Memory section codes.
   localparam logic [2:0] SEC_CODE = 3'h0;
   localparam logic [2:0] SEC_CONFIG = 3'h1;
   localparam logic [2:0] SEC_SIGNATURE = 3'h2;
   localparam logic [2:0] SEC_CALIB = 3'h3;
   localparam logic [2:0] SEC_LOCK = 3'h4;
   // Command decoder states.
   typedef enum logic [1:0] {
      ST_CMD = 2'b00,
      ST_STORE = 2'b01,
      ST_KEY = 2'b10
   } link_state_t;
   // Extra idle bits selected by the guard-time field.
   function automatic logic [7:0] guard_extra(input logic [2:0] gt);
      case (gt)
         3'h0: guard_extra = 8'h80;
         3'h1: guard_extra = 8'h40;
         3'h2: guard_extra = 8'h20;
         3'h3: guard_extra = 8'h10;
         3'h4: guard_extra = 8'h08;
         3'h5: guard_extra = 8'h04;
         3'h6: guard_extra = 8'h02;
         default: guard_extra = 8'h00;
      endcase
   endfunction
endpackage
